/* File: speed_threshold_pkg.sv */
/*
 * constants, register map and state layout of the speed threshold detector.
 * assumes nothing beyond a single clock domain.
 */
package speed_threshold_pkg;

	// ************************************************************
	// register map
	// ************************************************************
	localparam logic [11:0] zero_speed_threshold_addr   = 12'h14c;
	localparam logic [11:0] target_speed_threshold_addr = 12'h14e;
	localparam logic [11:0] irq_status_addr             = 12'h160;
	localparam logic [11:0] irq_clear_addr              = 12'h162;
	localparam logic [11:0] irq_enable_addr             = 12'h164;
	localparam logic [11:0] flag_state_addr             = 12'h166;

	// ************************************************************
	// reset values and limits
	// ************************************************************
	localparam logic [15:0] zero_speed_threshold_rst   = 16'h0064;
	localparam logic [15:0] zero_speed_threshold_max   = 16'h07d0;
	localparam logic [15:0] target_speed_threshold_rst = 16'h0bb8;
	localparam logic [15:0] target_speed_threshold_max = 16'h1388;

	// target threshold is whole rpm, speed is 0.1 rpm per count
	localparam logic [3:0]  target_scale = 4'ha;

	// ************************************************************
	// field positions
	// ************************************************************
	localparam int zero_bit   = 0;
	localparam int target_bit = 1;
	localparam int event_w    = 2;

	// common comparison width
	localparam int cmp_w = 24;

	typedef struct packed {
		logic [15:0]        zero_thr;
		logic [15:0]        target_thr;
		logic [event_w-1:0] irq_en;
		logic [event_w-1:0] irq_status;
		logic               zero_flag;
		logic               target_flag;
		logic [15:0]        rd_data;
	} state_t;

	typedef struct packed {
		logic        zero_speed_flag;
		logic        target_speed_reached_flag;
		logic        irq;
	} status_out_t;

endpackage : speed_threshold_pkg

/* File: magnitude_compare.sv */
/*
 * unsigned magnitude against threshold comparator.
 * assumes both operands are already scaled to the same unit.
 */
`timescale 1ns/10ps

module magnitude_compare #(
	parameter int W = 24
) (
	// operands
	input  wire logic [W-1:0] value,
	input  wire logic [W-1:0] threshold,
	// results
	output logic              at_or_below,
	output logic              at_or_above
);

	assign at_or_below = (value <= threshold);
	assign at_or_above = (value >= threshold);

endmodule : magnitude_compare

/* File: speed_threshold_detector.sv */
/*
 * speed threshold detector: zero-speed and target-speed outputs,
 * two threshold registers, sticky interrupt status.
 * assumes speed samples are signed, 0.1 rpm per count, synchronous to
 * clk_sys, qualified by speed_valid.
 */
//
// Function
// - zero-speed output turns on after a valid sample whose speed magnitude is at or below the zero threshold.
// - zero-speed output holds until speed magnitude rises strictly above the zero threshold.
// - zero threshold is 16 bits, 0.1 rpm per count, limited to 0..2000, reset to 100.
// - target-speed output turns on when speed reaches the target setting.
// - target comparison uses speed magnitude so both directions count.
// - target-speed output holds until speed magnitude falls strictly below the target.
//
`timescale 1ns/10ps

module speed_threshold_detector #(
	parameter int SPEED_W = 18
) (
	// clock and reset
	input  wire logic               clk_sys,
	input  wire logic               rst,
	// speed feedback
	input  wire logic [SPEED_W-1:0] speed,
	input  wire logic               speed_valid,
	// register port
	input  wire logic [11:0]        addr,
	input  wire logic [15:0]        wr_data,
	input  wire logic               wr_en,
	input  wire logic               rd_en,
	output logic      [15:0]        rd_data,
	// status outputs
	output logic                    zero_speed_flag,
	output logic                    target_speed_reached_flag,
	output logic                    irq
);

	// ************************************************************
	// speed magnitude and scaled thresholds
	// ************************************************************
	speed_threshold_pkg::state_t      state;
	speed_threshold_pkg::state_t      next_state;
	speed_threshold_pkg::status_out_t outs;

	logic [SPEED_W-1:0]                   neg_speed;
	logic [SPEED_W-1:0]                   mag;
	logic [speed_threshold_pkg::cmp_w-1:0] mag_ext;
	logic [speed_threshold_pkg::cmp_w-1:0] zero_ext;
	logic [speed_threshold_pkg::cmp_w-1:0] target_ext;
	logic [speed_threshold_pkg::cmp_w-1:0] target_prod;
	logic                                  zero_le;
	logic                                  zero_ge;
	logic                                  target_le;
	logic                                  target_ge;

	assign neg_speed = SPEED_W'(~speed + 1'b1);
	// absolute speed, forward or reverse
	assign mag       = speed[SPEED_W-1] ? neg_speed : speed;
	assign mag_ext   = speed_threshold_pkg::cmp_w'(mag);
	assign zero_ext  = speed_threshold_pkg::cmp_w'(state.zero_thr);
	// whole rpm scaled to 0.1 rpm counts
	assign target_prod = speed_threshold_pkg::cmp_w'(state.target_thr)
		* speed_threshold_pkg::cmp_w'(speed_threshold_pkg::target_scale);
	assign target_ext  = target_prod;

	magnitude_compare #(
		.W (speed_threshold_pkg::cmp_w)
	) u_zero_cmp (
		.value       (mag_ext),
		.threshold   (zero_ext),
		.at_or_below (zero_le),
		.at_or_above (zero_ge)
	);

	magnitude_compare #(
		.W (speed_threshold_pkg::cmp_w)
	) u_target_cmp (
		.value       (mag_ext),
		.threshold   (target_ext),
		.at_or_below (target_le),
		.at_or_above (target_ge)
	);

	// ************************************************************
	// next state
	// ************************************************************
	logic [speed_threshold_pkg::event_w-1:0] events;
	logic [speed_threshold_pkg::event_w-1:0] clear;
	logic                                    new_zero;
	logic                                    new_target;

	always_comb
	begin
		next_state = state;
		events     = '0;
		clear      = '0;
		new_zero   = state.zero_flag;
		new_target = state.target_flag;

		if (speed_valid)
		begin
			// on at or below, off only once strictly above
			new_zero   = zero_le;
			// on at or above, off only once strictly below
			new_target = target_ge;
		end
		next_state.zero_flag   = new_zero;
		next_state.target_flag = new_target;

		// rising edges of either output are events
		events[speed_threshold_pkg::zero_bit]   = new_zero & ~state.zero_flag;
		events[speed_threshold_pkg::target_bit] =
			new_target & ~state.target_flag;

		if (wr_en)
		begin
			case (addr)
				speed_threshold_pkg::zero_speed_threshold_addr:
				begin
					if (wr_data > speed_threshold_pkg::zero_speed_threshold_max)
						next_state.zero_thr =
							speed_threshold_pkg::zero_speed_threshold_max;
					else
						next_state.zero_thr = wr_data;
				end
				speed_threshold_pkg::target_speed_threshold_addr:
				begin
					if (wr_data >
						speed_threshold_pkg::target_speed_threshold_max)
						next_state.target_thr =
							speed_threshold_pkg::target_speed_threshold_max;
					else
						next_state.target_thr = wr_data;
				end
				speed_threshold_pkg::irq_clear_addr:
					clear = wr_data[speed_threshold_pkg::event_w-1:0];
				speed_threshold_pkg::irq_enable_addr:
					next_state.irq_en =
						wr_data[speed_threshold_pkg::event_w-1:0];
				default:
					clear = '0;
			endcase
		end

		// a new event wins over a clear in the same cycle
		next_state.irq_status = (state.irq_status & ~clear) | events;

		next_state.rd_data = '0;
		if (rd_en)
		begin
			case (addr)
				speed_threshold_pkg::zero_speed_threshold_addr:
					next_state.rd_data = state.zero_thr;
				speed_threshold_pkg::target_speed_threshold_addr:
					next_state.rd_data = state.target_thr;
				speed_threshold_pkg::irq_status_addr:
					next_state.rd_data = 16'(state.irq_status);
				speed_threshold_pkg::irq_enable_addr:
					next_state.rd_data = 16'(state.irq_en);
				speed_threshold_pkg::flag_state_addr:
					next_state.rd_data =
						16'({state.target_flag, state.zero_flag});
				default:
					next_state.rd_data = '0;
			endcase
		end
	end

	// ************************************************************
	// state register
	// ************************************************************
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			state.zero_thr    <= speed_threshold_pkg::zero_speed_threshold_rst;
			state.target_thr  <=
				speed_threshold_pkg::target_speed_threshold_rst;
			state.irq_en      <= '0;
			state.irq_status  <= '0;
			state.zero_flag   <= 1'b0;
			state.target_flag <= 1'b0;
			state.rd_data     <= '0;
		end
		else
			state <= next_state;
	end

	// ************************************************************
	// outputs
	// ************************************************************
	assign outs.zero_speed_flag           = state.zero_flag;
	assign outs.target_speed_reached_flag = state.target_flag;
	assign outs.irq = |(state.irq_status & state.irq_en);

	assign zero_speed_flag           = outs.zero_speed_flag;
	assign target_speed_reached_flag = outs.target_speed_reached_flag;
	assign irq                       = outs.irq;
	assign rd_data                   = state.rd_data;

endmodule : speed_threshold_detector

/* File: speed_threshold_asserts.sv */
/* checker of flag and register relations of the speed threshold detector.
   assumes it is bound to the detector top and sees only its ports. */
`timescale 1ns/10ps
module speed_threshold_checker #(
	parameter int SPEED_W = 18
) (
	input wire logic               clk_sys,
	input wire logic               rst,
	input wire logic [SPEED_W-1:0] speed,
	input wire logic               speed_valid,
	input wire logic [11:0]        addr,
	input wire logic [15:0]        wr_data,
	input wire logic               wr_en,
	input wire logic               rd_en,
	input wire logic [15:0]        rd_data,
	input wire logic               zero_speed_flag,
	input wire logic               target_speed_reached_flag,
	input wire logic               irq
);
	int          mag;
	int          tgt;
	logic [15:0] zt;
	logic [15:0] tt;
	assign mag = ($signed(speed) < 0) ? -$signed(speed) : $signed(speed);
	assign tgt = tt * 10;
	// shadow copies of the two clamped thresholds
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			zt <= 16'h0064;
			tt <= 16'h0bb8;
		end
		else if (wr_en && addr == 12'h14c)
			zt <= (wr_data > 16'h07d0) ? 16'h07d0 : wr_data;
		else if (wr_en && addr == 12'h14e)
			tt <= (wr_data > 16'h1388) ? 16'h1388 : wr_data;
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	a_zero_on: assert property (
		speed_valid && mag <= zt |=> zero_speed_flag) else $error("zero low");
	a_zero_off: assert property (
		speed_valid && mag > zt |=> !zero_speed_flag) else $error("zero high");
	a_zero_thr: assert property (
		rd_en && addr == 12'h14c |=> rd_data == $past(zt)) else $error("zthr");
	a_tgt_on: assert property (
		speed_valid && mag >= tgt |=> target_speed_reached_flag)
		else $error("target low");
	a_tgt_reverse: assert property (
		speed_valid && $signed(speed) < 0 |=>
		target_speed_reached_flag == ($past(mag) >= $past(tgt)))
		else $error("reverse target");
	a_tgt_off: assert property (
		speed_valid && mag < tgt |=> !target_speed_reached_flag)
		else $error("target high");
	a_tgt_thr: assert property (
		rd_en && addr == 12'h14e |=> rd_data == $past(tt)) else $error("tthr");
	a_flags_hold: assert property (
		!speed_valid |=> $stable({zero_speed_flag, target_speed_reached_flag}))
		else $error("flags moved");
	c_zero: cover property ($rose(zero_speed_flag));
	c_tgt: cover property ($rose(target_speed_reached_flag));
	c_irq: cover property ($rose(irq));
endmodule : speed_threshold_checker
bind speed_threshold_detector speed_threshold_checker #(
	.SPEED_W(SPEED_W)
) speed_threshold_checker_inst (
	.clk_sys(clk_sys), .rst(rst), .speed(speed), .speed_valid(speed_valid),
	.addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
	.rd_data(rd_data), .zero_speed_flag(zero_speed_flag),
	.target_speed_reached_flag(target_speed_reached_flag), .irq(irq)
);

/* File: flag_reader_model.sv */
/* controller model that counts turn-on events of the two drive outputs.
   assumes the outputs are synchronous to clk_sys. */
`timescale 1ns/10ps
module flag_reader_model (
	// clock and reset
	input  wire logic       clk_sys,
	input  wire logic       rst,
	// drive outputs
	input  wire logic       zero_speed_flag,
	input  wire logic       target_speed_reached_flag,
	// event counts
	output logic      [7:0] zero_count,
	output logic      [7:0] target_count
);
	logic zq;
	logic tq;
	always_ff @(posedge clk_sys)
	begin
		zq <= zero_speed_flag;
		tq <= target_speed_reached_flag;
		if (rst)
		begin
			zero_count   <= 8'h00;
			target_count <= 8'h00;
		end
		else
		begin
			zero_count   <= zero_count + {7'h00, zero_speed_flag & ~zq};
			target_count <= target_count + {7'h00, target_speed_reached_flag & ~tq};
		end
	end
endmodule : flag_reader_model

/* File: speed_threshold_detector_tb.sv */
/* self-checking bench of the speed threshold detector.
   assumes the detector and the flag reader model are compiled first. */
`timescale 1ns/10ps
module speed_threshold_detector_tb;
	logic        clk_sys = 1'b0;
	logic        rst = 1'b1;
	logic [17:0] speed = 18'h00000;
	logic        speed_valid = 1'b0;
	logic [11:0] addr = 12'h000;
	logic [15:0] wr_data = 16'h0000;
	logic        wr_en = 1'b0;
	logic        rd_en = 1'b0;
	logic [15:0] rd_data;
	logic        zf;
	logic        tf;
	logic        irq;
	logic [7:0]  zc;
	logic [7:0]  tc;
	int          n_errors = 0;
	int          check_count = 0;
	speed_threshold_detector speed_threshold_detector_inst (.clk_sys(clk_sys),
		.rst(rst), .speed(speed), .speed_valid(speed_valid), .addr(addr),
		.wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
		.zero_speed_flag(zf), .target_speed_reached_flag(tf), .irq(irq));
	flag_reader_model flag_reader_model_inst (.clk_sys(clk_sys), .rst(rst),
		.zero_speed_flag(zf), .target_speed_reached_flag(tf),
		.zero_count(zc), .target_count(tc));
	initial
	begin
		forever #4 clk_sys = ~clk_sys;
	end
	task automatic chk(input string w, input logic [15:0] e, input logic [15:0] g);
		check_count++;
		if (g !== e)
		begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", w, e, g);
		end
	endtask : chk
	task automatic wr(input logic [11:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		addr    <= a;
		wr_data <= d;
		wr_en   <= 1'b1;
		@(posedge clk_sys);
		wr_en   <= 1'b0;
	endtask : wr
	task automatic rd(input logic [11:0] a, input logic [15:0] e);
		@(posedge clk_sys);
		addr  <= a;
		rd_en <= 1'b1;
		@(posedge clk_sys);
		rd_en <= 1'b0;
		#1 chk("rd_data", e, rd_data);
	endtask : rd
	task automatic sp(input int v, input logic ez, input logic et);
		@(posedge clk_sys);
		speed       <= v[17:0];
		speed_valid <= 1'b1;
		@(posedge clk_sys);
		speed_valid <= 1'b0;
		#1 chk("zero_flag", {15'h0000, ez}, {15'h0000, zf});
		chk("target_flag", {15'h0000, et}, {15'h0000, tf});
	endtask : sp
	task automatic results;
		if (n_errors == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : results
	initial
	begin
		repeat (5000) @(posedge clk_sys);
		n_errors++;
		results();
	end
	initial
	begin
		repeat (6) @(posedge clk_sys);
		rst <= 1'b0;
		rd(12'h14c, 16'h0064);
		rd(12'h14e, 16'h0bb8);
		rd(12'h100, 16'h0000);
		wr(12'h164, 16'h0003);
		sp(100, 1'b1, 1'b0);
		sp(-100, 1'b1, 1'b0);
		sp(101, 1'b0, 1'b0);
		sp(30000, 1'b0, 1'b1);
		sp(-29999, 1'b0, 1'b0);
		sp(-30000, 1'b0, 1'b1);
		chk("irq", 16'h0001, {15'h0000, irq});
		rd(12'h160, 16'h0003);
		wr(12'h162, 16'h0003);
		wr(12'h164, 16'h0000);
		rd(12'h160, 16'h0000);
		sp(0, 1'b1, 1'b0);
		rd(12'h160, 16'h0001);
		chk("irq", 16'h0000, {15'h0000, irq});
		wr(12'h14c, 16'hffff);
		wr(12'h14e, 16'h2000);
		rd(12'h14c, 16'h07d0);
		rd(12'h14e, 16'h1388);
		sp(2001, 1'b0, 1'b0);
		sp(2000, 1'b1, 1'b0);
		sp(49999, 1'b0, 1'b0);
		sp(-50000, 1'b0, 1'b1);
		wr(12'h14e, 16'h000a);
		sp(-99, 1'b1, 1'b0);
		sp(100, 1'b1, 1'b1);
		rd(12'h166, 16'h0003);
		chk("zero_count", 16'h0004, {8'h00, zc});
		chk("target_count", 16'h0004, {8'h00, tc});
		results();
	end
endmodule : speed_threshold_detector_tb
